//--- irq_level_consts.svh
// register offsets, field positions and reset values for the priority level registers
// assumes a 32-bit apb slave, one aligned word per register
`ifndef IRQ_LEVEL_CONSTS_SVH
`define IRQ_LEVEL_CONSTS_SVH

// ---------------------------------------------------------------
// offsets
// ---------------------------------------------------------------
`define PWM_IRQ_LEVEL_OFFSET 12'h000
`define PIN_CHANGE_IRQ_LEVEL_OFFSET 12'h004

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define GEN4_LSB 8
`define GEN3_LSB 4
`define GEN2_LSB 0
`define PIN_CHANGE_LSB 12
`define PWM_IRQ_LEVEL_MASK 16'h0777
`define PIN_CHANGE_IRQ_LEVEL_MASK 16'h7000

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LEVEL_RESET 3'h4
`define LEVEL_DISABLED 3'h0
`define PWM_IRQ_LEVEL_RESET 16'h0444
`define PIN_CHANGE_IRQ_LEVEL_RESET 16'h4000

`endif

//--- irq_level_decode.sv
// decodes one 3-bit priority level field into an enable and a level
// assumes a level field held on the same clock
`timescale 1ns/1ps
`include "irq_level_consts.svh"
module irq_level_decode
	import irq_level_pkg::*;
(
	// field
	input wire level_type code,
	// decoded
	output logic enabled,
	output logic [2:0] level
);
	always_comb
	begin
		enabled = (code != `LEVEL_DISABLED);
		level = code;
	end
endmodule : irq_level_decode

//--- irq_level_pkg.sv
// types shared by the priority level register block
// assumes nothing beyond the constants header
package irq_level_pkg;
	typedef logic [2:0] level_type;
	typedef struct packed {
		level_type gen4;
		level_type gen3;
		level_type gen2;
		level_type pin_change;
		logic [15:0] rdata;
		logic ready;
		logic slverr;
		logic [3:0] en;
	} regs_type;
endpackage : irq_level_pkg

//--- irq_priority_level_regs.sv
// apb register block holding interrupt priority levels for four sources
// assumes a 32-bit apb master on pclk; the arbiter consumes the level outputs
`timescale 1ns/1ps
`include "irq_level_consts.svh"

// Notes on behaviour
// - a field holding 111 gives its source priority seven, the highest.
// - a field holding 001 gives priority one, the lowest active, and other codes their own value.
// - a field holding 000 disables its source so it never requests service.
// - the first register keeps the fourth generator's level in bits 10 to 8.
// - the first register keeps the third generator's level in bits 6 to 4.
// - the first register keeps the second generator's level in bits 2 to 0.
// - unimplemented bits of both registers read zero and ignore writes.
module irq_priority_level_regs
	import irq_level_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// levels to the arbiter
	output logic [2:0] gen4_irq_level,
	output logic [2:0] gen3_irq_level,
	output logic [2:0] gen2_irq_level,
	output logic [2:0] pin_change_irq_level,
	// source enables
	output logic gen4_irq_enabled,
	output logic gen3_irq_enabled,
	output logic gen2_irq_enabled,
	output logic pin_change_irq_enabled
);
	regs_type r;
	regs_type next_r;
	logic [3:0] en_comb;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] pwm_word(input regs_type s);
		pwm_word = {5'h00, s.gen4, 1'b0, s.gen3, 1'b0, s.gen2};
	endfunction : pwm_word

	function automatic logic [15:0] pin_word(input regs_type s);
		pin_word = {1'b0, s.pin_change, 12'h000};
	endfunction : pin_word

	// byte-lane merge so a narrow strobe leaves the other lane intact
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	logic access;
	logic [15:0] wpwm;
	logic [15:0] wpin;
	assign access = psel && penable;
	assign wpwm = merge(pwm_word(r), pwdata, pstrb);
	assign wpin = merge(pin_word(r), pwdata, pstrb);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// no wait state: ready rises with the access phase and falls after it
	always_comb
	begin
		next_r = r;
		next_r.ready = psel && !penable;
		next_r.slverr = 1'b0;
		next_r.en = en_comb;
		if (access && r.ready)
		begin
			next_r.ready = 1'b0;
			next_r.rdata = 16'h0000;
		end
		else if (psel && !penable)
		begin
			next_r.rdata = 16'h0000;
			if (paddr == `PWM_IRQ_LEVEL_OFFSET)
			begin
				next_r.rdata = pwm_word(r);
			end
			else if (paddr == `PIN_CHANGE_IRQ_LEVEL_OFFSET)
			begin
				next_r.rdata = pin_word(r);
			end
			else
			begin
				next_r.slverr = 1'b1;
			end
		end
		if (access && r.ready && pwrite)
		begin
			if (paddr == `PWM_IRQ_LEVEL_OFFSET)
			begin
				next_r.gen4 = wpwm[`GEN4_LSB +: 3];
				next_r.gen3 = wpwm[`GEN3_LSB +: 3];
				next_r.gen2 = wpwm[`GEN2_LSB +: 3];
			end
			else if (paddr == `PIN_CHANGE_IRQ_LEVEL_OFFSET)
			begin
				next_r.pin_change = wpin[`PIN_CHANGE_LSB +: 3];
			end
		end
		if (access && r.ready)
		begin
			next_r.slverr = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r.gen4 <= `LEVEL_RESET;
			r.gen3 <= `LEVEL_RESET;
			r.gen2 <= `LEVEL_RESET;
			r.pin_change <= `LEVEL_RESET;
			r.rdata <= 16'h0000;
			r.ready <= 1'b0;
			r.slverr <= 1'b0;
			r.en <= 4'hf;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// decode and outputs
	// ---------------------------------------------------------------
	irq_level_decode u_dec_gen4 (.code(r.gen4), .enabled(en_comb[3]), .level());
	irq_level_decode u_dec_gen3 (.code(r.gen3), .enabled(en_comb[2]), .level());
	irq_level_decode u_dec_gen2 (.code(r.gen2), .enabled(en_comb[1]), .level());
	irq_level_decode u_dec_pin (.code(r.pin_change), .enabled(en_comb[0]), .level());

	// enables registered in the state so every output leaves a flip-flop; lag of one cycle
	assign prdata = {16'h0000, r.rdata};
	assign pready = r.ready;
	assign pslverr = r.slverr;
	assign gen4_irq_level = r.gen4;
	assign gen3_irq_level = r.gen3;
	assign gen2_irq_level = r.gen2;
	assign pin_change_irq_level = r.pin_change;
	assign gen4_irq_enabled = r.en[3];
	assign gen3_irq_enabled = r.en[2];
	assign gen2_irq_enabled = r.en[1];
	assign pin_change_irq_enabled = r.en[0];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_write_pwm;
		psel && penable && pready && pwrite && paddr == `PWM_IRQ_LEVEL_OFFSET && pstrb == 4'hf;
	endsequence

	a_gen4_field_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_pwm |=> gen4_irq_level == $past(pwdata[10:8]))
		else $error("gen4 level not taken from bits 10:8");
	a_gen3_field_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_pwm |=> gen3_irq_level == $past(pwdata[6:4]))
		else $error("gen3 level not taken from bits 6:4");
	a_gen2_field_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_pwm |=> gen2_irq_level == $past(pwdata[2:0]))
		else $error("gen2 level not taken from bits 2:0");
	a_pin_field_write: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && pwrite && paddr == `PIN_CHANGE_IRQ_LEVEL_OFFSET
		&& pstrb[1] |=> pin_change_irq_level == $past(pwdata[14:12]))
		else $error("pin change level not taken from bits 14:12");
	a_reserved_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == `PWM_IRQ_LEVEL_OFFSET
		|-> (prdata & ~{16'h0000, `PWM_IRQ_LEVEL_MASK}) == 32'h0)
		else $error("first register reserved bits read nonzero");
	a_reserved_pin_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == `PIN_CHANGE_IRQ_LEVEL_OFFSET
		|-> (prdata & ~{16'h0000, `PIN_CHANGE_IRQ_LEVEL_MASK}) == 32'h0)
		else $error("second register reserved bits read nonzero");
	a_disabled_source: assert property (@(posedge pclk) disable iff (!presetn)
		gen2_irq_level == 3'h0 |=> !gen2_irq_enabled)
		else $error("disabled gen2 still enabled");
	a_level_seven_on: assert property (@(posedge pclk) disable iff (!presetn)
		pin_change_irq_level == 3'h7 |=> pin_change_irq_enabled)
		else $error("level seven source not enabled");
	a_level_one_on: assert property (@(posedge pclk) disable iff (!presetn)
		gen3_irq_level == 3'h1 |=> gen3_irq_enabled)
		else $error("level one source not enabled");
	a_reset_levels: assert property (@(posedge pclk)
		$rose(presetn) |-> gen4_irq_level == 3'h4 && pin_change_irq_level == 3'h4)
		else $error("reset level not four");
endmodule : irq_priority_level_regs

//--- irq_priority_level_regs_tb.sv
// self-checking bench for the priority level register block
// assumes the block answers apb transfers and holds its level outputs
`timescale 1ns/1ps
`include "irq_level_consts.svh"
module irq_priority_level_regs_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] l4, l3, l2, lc;
	logic e4, e3, e2, ec;
	logic [31:0] rd;
	logic err;
	int err_total = 0;
	int check_count = 0;
	irq_priority_level_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gen4_irq_level(l4), .gen3_irq_level(l3), .gen2_irq_level(l2),
		.pin_change_irq_level(lc), .gen4_irq_enabled(e4), .gen3_irq_enabled(e3),
		.gen2_irq_enabled(e2), .pin_change_irq_enabled(ec));
	initial
	begin
		forever #2 pclk = ~pclk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// request held until pready is seen high at a rising edge; answer taken at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		bit done;
		done = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && !done; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				done = 1'b1;
				rd = prdata;
				err = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
			end
		end
		if (!done)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask : apb
	// levels land one cycle after the write, enables one more
	task automatic outs(input logic [2:0] g4, g3, g2, pc);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("gen4 level", g4, l4);
		chk("gen3 level", g3, l3);
		chk("gen2 level", g2, l2);
		chk("pin change level", pc, lc);
		chk("enables", {g4 != 0, g3 != 0, g2 != 0, pc != 0}, {e4, e3, e2, ec});
	endtask : outs
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		outs(3'h4, 3'h4, 3'h4, 3'h4);
		apb(1'b0, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("first reg reset", 32'h0444, rd);
		apb(1'b0, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("second reg reset", 32'h4000, rd);
		$display("test reset done");
	endtask : t_reset
	// every code on every field; pin change copies gen4, and gen3 equals gen2 at two steps
	task automatic t_codes;
		logic [2:0] a, b, c;
		for (int i = 0; i < 8; i++)
		begin
			a = 3'(i);
			b = 3'(7 - i);
			c = 3'(i + 3);
			apb(1'b1, `PWM_IRQ_LEVEL_OFFSET, {21'h0, a, 1'b0, b, 1'b0, c}, 4'hf);
			apb(1'b1, `PIN_CHANGE_IRQ_LEVEL_OFFSET, {17'h0, a, 12'h0}, 4'hf);
			outs(a, b, c, a);
			apb(1'b0, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
			chk("first reg readback", {21'h0, a, 1'b0, b, 1'b0, c}, rd);
			apb(1'b0, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
			chk("second reg readback", {17'h0, a, 12'h0}, rd);
		end
		$display("test codes done");
	endtask : t_codes
	task automatic t_reserved;
		apb(1'b1, `PWM_IRQ_LEVEL_OFFSET, 32'hffffffff, 4'hf);
		apb(1'b0, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("first reg reserved", 32'h0777, rd);
		apb(1'b1, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'hffffffff, 4'hf);
		apb(1'b0, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("second reg reserved", 32'h7000, rd);
		apb(1'b1, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'h2);
		apb(1'b1, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h0, 4'h1);
		outs(3'h0, 3'h7, 3'h7, 3'h7);
		$display("test reserved done");
	endtask : t_reserved
	task automatic t_unmapped;
		apb(1'b1, 12'h008, 32'h0, 4'hf);
		chk("unmapped write error", 32'h1, {31'h0, err});
		apb(1'b0, 12'h008, 32'h0, 4'hf);
		chk("unmapped read data", 32'h0, rd);
		chk("unmapped read error", 32'h1, {31'h0, err});
		apb(1'b0, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("first reg kept", 32'h0077, rd);
		$display("test unmapped done");
	endtask : t_unmapped
	// reset in mid-run returns every field to its default
	task automatic t_midreset;
		apb(1'b1, `PWM_IRQ_LEVEL_OFFSET, 32'h00000123, 4'hf);
		apb(1'b1, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h00005000, 4'hf);
		outs(3'h1, 3'h2, 3'h3, 3'h5);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("levels in reset", 32'h00004444, {16'h0, 1'b0, l4, 1'b0, l3, 1'b0, l2, 1'b0, lc});
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		outs(3'h4, 3'h4, 3'h4, 3'h4);
		apb(1'b0, `PWM_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("first reg after reset", 32'h0444, rd);
		apb(1'b0, `PIN_CHANGE_IRQ_LEVEL_OFFSET, 32'h0, 4'hf);
		chk("second reg after reset", 32'h4000, rd);
		$display("test midreset done");
	endtask : t_midreset
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_codes();
		t_reserved();
		t_unmapped();
		t_midreset();
		tally_and_finish();
	end
endmodule : irq_priority_level_regs_tb
